// ===== rtl/ddg_pkg.sv
// constants, types and command coding for the ddr command timing guard
package ddg_pkg;
   // ======================================================================
   // clocking
   localparam int CLK_PS = 10000;
   localparam int CK_DIV = 2;
   localparam int NB     = 4;
   localparam int CW     = 4;
   localparam int TW     = 13;

   // ======================================================================
   // printed times
   localparam int  T_RAS_MIN_NS  = 40;
   localparam int  T_RAS_MAX_NS  = 70000;
   localparam int  T_RAP_NS      = 15;
   localparam int  T_RC_NS       = 55;
   localparam int  T_RFC_NS      = 70;
   localparam int  T_RCD_NS      = 15;
   localparam int  T_RP_NS       = 15;
   localparam int  T_WR_NS       = 15;
   localparam int  T_MRD_NS      = 2;
   localparam int  T_RRD_NS      = 10;
   localparam int  T_WTR_CK      = 2;
   localparam real T_REFC_US     = 70.3;
   localparam real T_REFC_SML_US = 140.6;

   // ======================================================================
   // conversion to ref_clk cycles
   function automatic int ceil_cyc(input int ns);
      int c;
      c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
      return (c < 1) ? 1 : c;
   endfunction : ceil_cyc

   localparam int RAS_MIN_CYC     = ceil_cyc(T_RAS_MIN_NS);
   localparam int RAS_MAX_CYC_DEF = (T_RAS_MAX_NS * 1000) / CLK_PS;
   localparam int RAP_CYC         = ceil_cyc(T_RAP_NS);
   localparam int RC_CYC          = ceil_cyc(T_RC_NS);
   localparam int RFC_CYC         = ceil_cyc(T_RFC_NS);
   localparam int RCD_CYC         = ceil_cyc(T_RCD_NS);
   localparam int RP_CYC          = ceil_cyc(T_RP_NS);
   localparam int WR_CYC          = ceil_cyc(T_WR_NS);
   localparam int MRD_CYC         = ceil_cyc(T_MRD_NS);
   localparam int RRD_CYC         = ceil_cyc(T_RRD_NS);
   localparam int REFC_CYC_DEF    = int'($floor(T_REFC_US * 1.0e6 / real'(CLK_PS)));
   localparam int REFC_SML_CYC    = int'($floor(T_REFC_SML_US * 1.0e6 / real'(CLK_PS)));
   localparam int FORCE_MARGIN    = 64;
   // address bit that carries auto precharge on column commands
   localparam int AP_BIT          = 10;

   // write strobe sequence: counts 5 to 3 preamble, 2 high, 1 low, 0 released
   localparam int DQS_SEQ_LEN = 5;
   localparam int DQS_HIGH_AT = 2;
   localparam int WGAP_CYC    = DQS_SEQ_LEN - 1;
   // read may be sampled only two memory clocks after the last write beat
   localparam int WTR_CYC     = DQS_SEQ_LEN + (T_WTR_CK - 1) * CK_DIV;

   typedef logic [CW-1:0] ddg_cnt_t;
   typedef logic [TW-1:0] ddg_tmr_t;

   localparam ddg_cnt_t L_RAS  = ddg_cnt_t'(RAS_MIN_CYC - 1);
   localparam ddg_cnt_t L_RAP  = ddg_cnt_t'(RAP_CYC - 1);
   localparam ddg_cnt_t L_RC   = ddg_cnt_t'(RC_CYC - 1);
   localparam ddg_cnt_t L_RFC  = ddg_cnt_t'(RFC_CYC - 1);
   localparam ddg_cnt_t L_RCD  = ddg_cnt_t'(RCD_CYC - 1);
   localparam ddg_cnt_t L_RP   = ddg_cnt_t'(RP_CYC - 1);
   localparam ddg_cnt_t L_RPRA = ddg_cnt_t'(RP_CYC + CK_DIV - 1);
   localparam ddg_cnt_t L_RPWA = ddg_cnt_t'(RP_CYC + WR_CYC + DQS_SEQ_LEN - 1);
   localparam ddg_cnt_t L_MRD  = ddg_cnt_t'(MRD_CYC - 1);
   localparam ddg_cnt_t L_RRD  = ddg_cnt_t'(RRD_CYC - 1);
   localparam ddg_cnt_t L_WTR  = ddg_cnt_t'(WTR_CYC - 1);
   localparam ddg_cnt_t L_WGAP = ddg_cnt_t'(WGAP_CYC - 1);
   localparam ddg_cnt_t L_DQS  = ddg_cnt_t'(DQS_SEQ_LEN);
   localparam ddg_cnt_t DQS_HI = ddg_cnt_t'(DQS_HIGH_AT);

   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_REF, CMD_MRS
   } ddg_cmd_e;

   // ras_n, cas_n, we_n levels for each command
   function automatic logic [2:0] cmd_pins(input ddg_cmd_e c);
      case (c)
         CMD_ACT: return 3'h3;
         CMD_RD:  return 3'h5;
         CMD_WR:  return 3'h4;
         CMD_PRE: return 3'h2;
         CMD_REF: return 3'h1;
         CMD_MRS: return 3'h0;
         default: return 3'h7;
      endcase
   endfunction : cmd_pins
endpackage : ddg_pkg

// ===== rtl/ddg_cmd_guard.sv
// host-side ddr command issuer keeping command spacing, refresh and write strobe timing
// Functional notes
// [RULE_01] row open 40 ns to 70 us
// [RULE_02] activate to read-autoprecharge at least 15 ns
// [RULE_03] activate to activate or refresh 55 ns
// [RULE_04] refresh to next command at least 70 ns
// [RULE_05] activate to read or write 15 ns
// [RULE_06] mode load to next command 2 ns
// [RULE_07] first write strobe edge 0.72-1.28 clocks
// [RULE_08] strobe fall 0.2 clock before rise
// [RULE_09] strobe fall 0.2 clock after rise
// [RULE_10] strobe high and low at least 0.35 clock
// [RULE_11] activates of different banks 10 ns apart
// [RULE_12] last write data to read two clocks
// [RULE_13] refresh at least every 70.3 us
// [RULE_14] no postponed or bursted refreshes beyond eight
// [RULE_15] round nanosecond minimums up to whole cycles
module ddg_cmd_guard #(
   parameter int REFC_CYC    = ddg_pkg::REFC_CYC_DEF,
   parameter int RAS_MAX_CYC = ddg_pkg::RAS_MAX_CYC_DEF
) (
   input  wire logic               ref_clk,
   input  wire logic               rst_n,
   input  wire logic               req_valid,
   output logic                    req_ready,
   input  wire ddg_pkg::ddg_cmd_e  req_cmd,
   input  wire logic [1:0]         req_bank,
   input  wire logic [12:0]        req_addr,
   input  wire logic               req_auto_pre,
   output logic                    refresh_pending,
   output logic                    ddr_ck,
   output logic                    ddr_ck_n,
   output logic                    ddr_cs_n,
   output logic                    ddr_ras_n,
   output logic                    ddr_cas_n,
   output logic                    ddr_we_n,
   output logic [1:0]              ddr_ba,
   output logic [12:0]             ddr_addr,
   output logic                    ddr_dqs_o,
   output logic                    ddr_dqs_oe
);
   localparam ddg_pkg::ddg_tmr_t REF_REQ = ddg_pkg::ddg_tmr_t'(REFC_CYC / 2);
   localparam ddg_pkg::ddg_tmr_t FORCE_AT =
      ddg_pkg::ddg_tmr_t'(RAS_MAX_CYC - ddg_pkg::FORCE_MARGIN);

   function automatic ddg_pkg::ddg_cnt_t dec(input ddg_pkg::ddg_cnt_t c);
      return (c == '0) ? c : c - 1'b1;
   endfunction : dec

   ddg_pkg::ddg_cnt_t ras_cnt_r [ddg_pkg::NB];
   ddg_pkg::ddg_cnt_t rc_cnt_r  [ddg_pkg::NB];
   ddg_pkg::ddg_cnt_t rcd_cnt_r [ddg_pkg::NB];
   ddg_pkg::ddg_cnt_t rap_cnt_r [ddg_pkg::NB];
   ddg_pkg::ddg_cnt_t rp_cnt_r  [ddg_pkg::NB];
   ddg_pkg::ddg_tmr_t open_tm_r [ddg_pkg::NB];
   logic [ddg_pkg::NB-1:0] open_r;
   ddg_pkg::ddg_cnt_t rrd_cnt_r;
   ddg_pkg::ddg_cnt_t rfc_cnt_r;
   ddg_pkg::ddg_cnt_t mrd_cnt_r;
   ddg_pkg::ddg_cnt_t wtr_cnt_r;
   ddg_pkg::ddg_cnt_t wgap_cnt_r;
   ddg_pkg::ddg_cnt_t dqs_cnt_r;
   ddg_pkg::ddg_cnt_t dqs_cnt_nxt;
   ddg_pkg::ddg_tmr_t ref_tm_r;
   ddg_pkg::ddg_cmd_e iss_cmd;
   logic [1:0]        iss_bank;
   logic [12:0]       iss_addr;
   logic              iss_ap;
   logic              idle_ok;
   logic              ref_due;

   assign ref_due         = (ref_tm_r >= REF_REQ); // RULE_13
   assign refresh_pending = ref_due;

   // ======================================================================
   // command selection, one slot per memory clock
   always_comb begin
      logic             pre_hit;
      logic [1:0]       pre_b;
      logic             ok;
      pre_hit   = 1'b0;
      pre_b     = '0;
      ok        = 1'b0;
      iss_cmd   = ddg_pkg::CMD_NOP;
      iss_bank  = '0;
      iss_addr  = '0;
      iss_ap    = 1'b0;
      req_ready = 1'b0;
      idle_ok   = (open_r == '0) && (rfc_cnt_r == '0) && (mrd_cnt_r == '0);
      for (int b = 0; b < ddg_pkg::NB; b++) begin
         if (rp_cnt_r[b] != '0 || rc_cnt_r[b] != '0) begin
            idle_ok = 1'b0; // RULE_03
         end
         // close rows before their open limit or when a refresh is due
         if (!pre_hit && open_r[b] && ras_cnt_r[b] == '0 &&
             (ref_due || open_tm_r[b] >= FORCE_AT)) begin // RULE_01 RULE_14
            pre_hit = 1'b1;
            pre_b   = 2'(b);
         end
      end
      if (ddr_ck) begin
         if (pre_hit && rfc_cnt_r == '0 && mrd_cnt_r == '0) begin
            iss_cmd  = ddg_pkg::CMD_PRE;
            iss_bank = pre_b;
         end else if (ref_due && idle_ok) begin
            iss_cmd = ddg_pkg::CMD_REF; // RULE_13
         end else if (req_valid) begin
            ok = (rfc_cnt_r == '0) && (mrd_cnt_r == '0); // RULE_04 RULE_06
            unique case (req_cmd)
               ddg_pkg::CMD_ACT: ok = ok && !ref_due && !open_r[req_bank] &&
                                      rc_cnt_r[req_bank] == '0 &&
                                      rp_cnt_r[req_bank] == '0 &&
                                      rrd_cnt_r == '0; // RULE_03 RULE_11
               ddg_pkg::CMD_RD:  ok = ok && rcd_cnt_r[req_bank] == '0 &&
                                      wtr_cnt_r == '0 &&
                                      (!req_auto_pre ||
                                       rap_cnt_r[req_bank] == '0); // RULE_02 RULE_05 RULE_12
               ddg_pkg::CMD_WR:  ok = ok && rcd_cnt_r[req_bank] == '0 &&
                                      wgap_cnt_r == '0; // RULE_05
               ddg_pkg::CMD_PRE: ok = ok && ras_cnt_r[req_bank] == '0; // RULE_01
               ddg_pkg::CMD_REF: ok = idle_ok;
               ddg_pkg::CMD_MRS: ok = idle_ok;
               ddg_pkg::CMD_NOP: ok = 1'b1;
               default:          ok = 1'b0;
            endcase
            if (ok) begin
               req_ready = 1'b1;
               iss_cmd   = req_cmd;
               iss_bank  = req_bank;
               iss_addr  = req_addr;
               iss_ap    = req_auto_pre;
            end
         end
      end
   end

   // ======================================================================
   // per-bank timing
   for (genvar b = 0; b < ddg_pkg::NB; b++) begin : g_bank
      logic hit;
      logic act_b;
      assign hit   = (iss_bank == 2'(b));
      assign act_b = hit && iss_cmd == ddg_pkg::CMD_ACT;

      always_ff @(posedge ref_clk or negedge rst_n) begin
         if (!rst_n) begin
            ras_cnt_r[b] <= '0;
            rc_cnt_r[b]  <= '0;
            rcd_cnt_r[b] <= '0;
            rap_cnt_r[b] <= '0;
            rp_cnt_r[b]  <= '0;
            open_tm_r[b] <= '0;
            open_r[b]    <= 1'b0;
         end else begin
            ras_cnt_r[b] <= dec(ras_cnt_r[b]);
            rc_cnt_r[b]  <= dec(rc_cnt_r[b]);
            rcd_cnt_r[b] <= dec(rcd_cnt_r[b]);
            rap_cnt_r[b] <= dec(rap_cnt_r[b]);
            rp_cnt_r[b]  <= dec(rp_cnt_r[b]);
            if (open_r[b] && open_tm_r[b] != '1) begin
               open_tm_r[b] <= open_tm_r[b] + 1'b1;
            end
            if (act_b) begin
               ras_cnt_r[b] <= ddg_pkg::L_RAS; // RULE_01 RULE_15
               rc_cnt_r[b]  <= ddg_pkg::L_RC; // RULE_03
               rcd_cnt_r[b] <= ddg_pkg::L_RCD; // RULE_05
               rap_cnt_r[b] <= ddg_pkg::L_RAP; // RULE_02
               open_tm_r[b] <= '0;
               open_r[b]    <= 1'b1;
            end else if (hit && iss_cmd == ddg_pkg::CMD_PRE) begin
               rp_cnt_r[b] <= ddg_pkg::L_RP;
               open_r[b]   <= 1'b0;
            end else if (hit && iss_ap && iss_cmd == ddg_pkg::CMD_RD) begin
               rp_cnt_r[b] <= ddg_pkg::L_RPRA;
               open_r[b]   <= 1'b0;
            end else if (hit && iss_ap && iss_cmd == ddg_pkg::CMD_WR) begin
               rp_cnt_r[b] <= ddg_pkg::L_RPWA;
               open_r[b]   <= 1'b0;
            end
         end
      end

      property p_ras_min;
         @(posedge ref_clk) disable iff (!rst_n)
         act_b |=> !(hit && iss_cmd == ddg_pkg::CMD_PRE) [*3];
      endproperty
      a_ras_min: assert property (p_ras_min) else $error("precharge before row min time"); // RULE_01

      property p_ras_max;
         @(posedge ref_clk) disable iff (!rst_n)
         open_r[b] |-> open_tm_r[b] < ddg_pkg::ddg_tmr_t'(RAS_MAX_CYC);
      endproperty
      a_ras_max: assert property (p_ras_max) else $error("row open too long"); // RULE_01

      property p_rap;
         @(posedge ref_clk) disable iff (!rst_n)
         act_b |=> !(hit && iss_ap && iss_cmd == ddg_pkg::CMD_RD);
      endproperty
      a_rap: assert property (p_rap) else $error("read with precharge too early"); // RULE_02

      property p_rc;
         @(posedge ref_clk) disable iff (!rst_n)
         act_b |=> !(act_b || iss_cmd == ddg_pkg::CMD_REF) [*5];
      endproperty
      a_rc: assert property (p_rc) else $error("activate cycle too short"); // RULE_03

      property p_rcd;
         @(posedge ref_clk) disable iff (!rst_n)
         act_b |=> !(hit && (iss_cmd == ddg_pkg::CMD_RD || iss_cmd == ddg_pkg::CMD_WR));
      endproperty
      a_rcd: assert property (p_rcd) else $error("column access too soon"); // RULE_05
   end

   // ======================================================================
   // global spacing and refresh timer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rrd_cnt_r  <= '0;
         rfc_cnt_r  <= '0;
         mrd_cnt_r  <= '0;
         wtr_cnt_r  <= '0;
         wgap_cnt_r <= '0;
      end else begin
         rrd_cnt_r  <= (iss_cmd == ddg_pkg::CMD_ACT) ? ddg_pkg::L_RRD : dec(rrd_cnt_r); // RULE_11
         rfc_cnt_r  <= (iss_cmd == ddg_pkg::CMD_REF) ? ddg_pkg::L_RFC : dec(rfc_cnt_r); // RULE_04
         mrd_cnt_r  <= (iss_cmd == ddg_pkg::CMD_MRS) ? ddg_pkg::L_MRD : dec(mrd_cnt_r); // RULE_06
         wtr_cnt_r  <= (iss_cmd == ddg_pkg::CMD_WR) ? ddg_pkg::L_WTR : dec(wtr_cnt_r); // RULE_12
         wgap_cnt_r <= (iss_cmd == ddg_pkg::CMD_WR) ? ddg_pkg::L_WGAP : dec(wgap_cnt_r);
      end
   end

   // one refresh per half interval, never saved up
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ref_tm_r <= '0;
      end else if (iss_cmd == ddg_pkg::CMD_REF) begin
         ref_tm_r <= '0; // RULE_13 RULE_14
      end else if (ref_tm_r != '1) begin
         ref_tm_r <= ref_tm_r + 1'b1;
      end
   end

   // ======================================================================
   // memory clock and command pins, held from clock fall to clock fall
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ddr_ck   <= 1'b0;
         ddr_ck_n <= 1'b1;
      end else begin
         ddr_ck   <= !ddr_ck;
         ddr_ck_n <= ddr_ck;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         ddr_cs_n  <= 1'b1;
         {ddr_ras_n, ddr_cas_n, ddr_we_n} <= 3'h7;
         ddr_ba    <= '0;
         ddr_addr  <= '0;
      end else if (ddr_ck) begin
         ddr_cs_n  <= (iss_cmd == ddg_pkg::CMD_NOP);
         {ddr_ras_n, ddr_cas_n, ddr_we_n} <= ddg_pkg::cmd_pins(iss_cmd);
         ddr_ba    <= iss_bank;
         ddr_addr  <= iss_addr;
         if (iss_cmd == ddg_pkg::CMD_RD || iss_cmd == ddg_pkg::CMD_WR) begin
            ddr_addr[ddg_pkg::AP_BIT] <= iss_ap;
         end else if (iss_cmd == ddg_pkg::CMD_PRE) begin
            ddr_addr[ddg_pkg::AP_BIT] <= 1'b0;
         end
      end
   end

   // ======================================================================
   // write strobe: preamble, one high beat on a clock rise, low, release
   assign dqs_cnt_nxt = (iss_cmd == ddg_pkg::CMD_WR) ? ddg_pkg::L_DQS : dec(dqs_cnt_r);

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         dqs_cnt_r  <= '0;
         ddr_dqs_o  <= 1'b0;
         ddr_dqs_oe <= 1'b0;
      end else begin
         dqs_cnt_r  <= dqs_cnt_nxt;
         ddr_dqs_o  <= (dqs_cnt_nxt == ddg_pkg::DQS_HI); // RULE_07 RULE_08 RULE_09 RULE_10
         ddr_dqs_oe <= (dqs_cnt_nxt != '0);
      end
   end

   // ======================================================================
   // checks
   property p_rfc;
      @(posedge ref_clk) disable iff (!rst_n)
      iss_cmd == ddg_pkg::CMD_REF |=> (iss_cmd == ddg_pkg::CMD_NOP) [*6];
   endproperty
   a_rfc: assert property (p_rfc) else $error("command inside refresh time"); // RULE_04

   property p_mrd;
      @(posedge ref_clk) disable iff (!rst_n)
      iss_cmd == ddg_pkg::CMD_MRS |=> iss_cmd == ddg_pkg::CMD_NOP;
   endproperty
   a_mrd: assert property (p_mrd) else $error("command too soon after mode load"); // RULE_06

   property p_dqss;
      @(posedge ref_clk) disable iff (!rst_n)
      iss_cmd == ddg_pkg::CMD_WR |-> ##4 ($rose(ddr_dqs_o) && $rose(ddr_ck) && ddr_dqs_oe);
   endproperty
   a_dqss: assert property (p_dqss) else $error("first strobe edge misplaced"); // RULE_07

   property p_dss;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(ddr_dqs_o) |-> !ddr_ck && ddr_dqs_oe;
   endproperty
   a_dss: assert property (p_dss) else $error("strobe fall too close to clock rise"); // RULE_08

   property p_dsh;
      @(posedge ref_clk) disable iff (!rst_n)
      $fell(ddr_dqs_o) |-> $past(ddr_ck);
   endproperty
   a_dsh: assert property (p_dsh) else $error("strobe fall too soon after clock rise"); // RULE_09

   property p_dqs_hl;
      @(posedge ref_clk) disable iff (!rst_n)
      $rose(ddr_dqs_o) |=> !ddr_dqs_o ##1 !ddr_dqs_o;
   endproperty
   a_dqs_hl: assert property (p_dqs_hl) else $error("strobe pulse too short"); // RULE_10

   property p_rrd;
      @(posedge ref_clk) disable iff (!rst_n)
      iss_cmd == ddg_pkg::CMD_ACT |=> iss_cmd != ddg_pkg::CMD_ACT;
   endproperty
   a_rrd: assert property (p_rrd) else $error("activates too close"); // RULE_11

   property p_wtr;
      @(posedge ref_clk) disable iff (!rst_n)
      iss_cmd == ddg_pkg::CMD_WR |=> (iss_cmd != ddg_pkg::CMD_RD) [*6];
   endproperty
   a_wtr: assert property (p_wtr) else $error("read too soon after write"); // RULE_12

   property p_refc;
      @(posedge ref_clk) disable iff (!rst_n)
      ref_tm_r < ddg_pkg::ddg_tmr_t'(REFC_CYC);
   endproperty
   a_refc: assert property (p_refc) else $error("refresh interval exceeded"); // RULE_13
endmodule : ddg_cmd_guard

// ===== dv/ddg_dram_model.sv
// device model: watches command pins and write strobe, counts timing faults
module ddg_dram_model #(
   parameter real REFC_NS    = 70300.0,
   parameter real RAS_MAX_NS = 70000.0
) (
   input  wire logic        ddr_ck,
   input  wire logic        ddr_ck_n,
   input  wire logic        ddr_cs_n,
   input  wire logic        ddr_ras_n,
   input  wire logic        ddr_cas_n,
   input  wire logic        ddr_we_n,
   input  wire logic [1:0]  ddr_ba,
   input  wire logic [12:0] ddr_addr,
   input  wire logic        ddr_dqs_o,
   input  wire logic        ddr_dqs_oe,
   output int               viol_cnt = 0,
   output int               ref_cnt = 0,
   output logic [3:0]       open_banks = 4'h0
);
   timeunit 1ns;
   timeprecision 1ps;
   real        t_act[4] = '{-1.0e6, -1.0e6, -1.0e6, -1.0e6};
   real        t_any = -1.0e6, t_ref = 0.0, t_mrs = -1.0e6, t_wr = -1.0e6;
   real        t_fall = -1.0e6, t_ckr = 0.0, tck = 20.0, t_low = 0.0, t_rise = 0.0;
   bit         wr_wait, fall_wait;
   int         ref_run;
   logic [2:0] code;

   task automatic flag(input bit bad);
      if (bad) viol_cnt++;
   endtask : flag

   // ======================================================================
   // commands, sampled on the memory clock rise
   always @(posedge ddr_ck) begin
      tck = $realtime - t_ckr;
      t_ckr = $realtime;
      flag(ddr_ck_n !== ~ddr_ck);
      if (fall_wait) flag($realtime - t_fall < 0.2 * tck);
      fall_wait = 0;
      foreach (t_act[b]) if (open_banks[b]) flag($realtime - t_act[b] > RAS_MAX_NS);
      flag($realtime - t_ref > REFC_NS);
      code = {ddr_ras_n, ddr_cas_n, ddr_we_n};
      if (ddr_cs_n === 1'b0) begin
         flag($realtime - t_ref < 70.0);
         flag($realtime - t_mrs < 2.0);
         if (code == 3'h1) ref_run = ($realtime - t_ref < REFC_NS / 8.0) ? ref_run + 1 : 1;
         flag(ref_run > 8);
         case (code)
            3'h3: begin
               flag(open_banks[ddr_ba] || $realtime - t_act[ddr_ba] < 55.0);
               flag($realtime - t_any < 10.0);
               t_act[ddr_ba] = $realtime;
               t_any = $realtime;
               open_banks[ddr_ba] = 1'b1;
            end
            3'h4, 3'h5: begin
               flag($realtime - t_act[ddr_ba] < 15.0);
               if (code == 3'h5) flag($realtime - t_fall < 2.0 * tck);
               else begin
                  t_wr = $realtime;
                  wr_wait = 1;
               end
               if (ddr_addr[10]) open_banks[ddr_ba] = 1'b0;
            end
            3'h2: begin
               flag($realtime - t_act[ddr_ba] < 40.0);
               open_banks[ddr_ba] = 1'b0;
            end
            3'h1: begin
               flag(open_banks != 4'h0 || $realtime - t_any < 55.0);
               t_ref = $realtime;
               ref_cnt++;
            end
            3'h0: t_mrs = $realtime;
            default: ;
         endcase
      end
   end

   // ======================================================================
   // write strobe shape
   always @(posedge ddr_dqs_o) if (ddr_dqs_oe) begin
      flag($realtime - t_low < 0.35 * tck);
      if (wr_wait) flag($realtime - t_wr < 0.72 * tck || $realtime - t_wr > 1.28 * tck);
      wr_wait = 0;
      t_rise = $realtime;
   end
   always @(negedge ddr_dqs_o) if (ddr_dqs_oe) begin
      flag($realtime - t_rise < 0.35 * tck);
      flag($realtime - t_ckr < 0.2 * tck);
      t_fall = $realtime;
      t_low = $realtime;
      fall_wait = 1;
   end
   always @(posedge ddr_dqs_oe) t_low = $realtime;
   // ignore the drop to idle at reset, before any strobe was driven
   always @(negedge ddr_dqs_oe) if (t_low > 0.0) flag($realtime - t_low < 0.35 * tck);
endmodule : ddg_dram_model

// ===== dv/test_ddr_command_timing_guard.sv
// testbench: drives the command guard and judges spacing against a device model
module test_ddr_command_timing_guard;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int REFC = 400;
   localparam int RASX = 300;
   logic              ref_clk, rst_n, req_valid, req_ready, req_auto_pre, refresh_pending;
   ddg_pkg::ddg_cmd_e req_cmd;
   logic [1:0]        req_bank, ddr_ba;
   logic [12:0]       req_addr, ddr_addr;
   logic              ddr_ck, ddr_ck_n, ddr_cs_n, ddr_ras_n, ddr_cas_n, ddr_we_n;
   logic              ddr_dqs_o, ddr_dqs_oe, saw_pend = 1'b0, saw_dqs = 1'b0;
   logic [3:0]        open_banks;
   int                viol_cnt, ref_cnt, cyc = 0, n_errors = 0, samples_checked = 0;

   ddg_cmd_guard #(.REFC_CYC(REFC), .RAS_MAX_CYC(RASX)) DUT (
      .ref_clk(ref_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
      .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
      .req_auto_pre(req_auto_pre), .refresh_pending(refresh_pending), .ddr_ck(ddr_ck),
      .ddr_ck_n(ddr_ck_n), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
      .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
      .ddr_dqs_o(ddr_dqs_o), .ddr_dqs_oe(ddr_dqs_oe));

   ddg_dram_model #(.REFC_NS(REFC * 10.0), .RAS_MAX_NS(RASX * 10.0)) dram (
      .ddr_ck(ddr_ck), .ddr_ck_n(ddr_ck_n), .ddr_cs_n(ddr_cs_n), .ddr_ras_n(ddr_ras_n),
      .ddr_cas_n(ddr_cas_n), .ddr_we_n(ddr_we_n), .ddr_ba(ddr_ba), .ddr_addr(ddr_addr),
      .ddr_dqs_o(ddr_dqs_o), .ddr_dqs_oe(ddr_dqs_oe), .viol_cnt(viol_cnt),
      .ref_cnt(ref_cnt), .open_banks(open_banks));

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (refresh_pending === 1'b1) saw_pend <= 1'b1;
      if (ddr_dqs_oe === 1'b1 && ddr_dqs_o === 1'b1) saw_dqs <= 1'b1;
   end

   // ======================================================================
   // helpers
   // whole ref cycles for a time, then the next memory clock slot
   function automatic int slot(input int ns);
      int c;
      c = (ns + 9) / 10;
      return (c + 1) / 2 * 2;
   endfunction : slot

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask : check

   task automatic issue(input ddg_pkg::ddg_cmd_e c, input logic [1:0] b, input logic ap,
                        output int t);
      int k;
      bit got;
      @(posedge ref_clk);
      req_valid    <= 1'b1;
      req_cmd      <= c;
      req_bank     <= b;
      req_addr     <= 13'h0123;
      req_auto_pre <= ap;
      k = 0;
      got = 0;
      while (!got && k < 400) begin
         @(negedge ref_clk);
         got = (req_ready === 1'b1);
         @(posedge ref_clk);
         k++;
      end
      t = cyc;
      req_valid <= 1'b0;
      check("command taken", got, 1'b1);
   endtask : issue

   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   // ======================================================================
   // scenarios
   task automatic sc_reset_state;
      check("ck in reset", ddr_ck, 1'b0);
      check("cs_n in reset", ddr_cs_n, 1'b1);
      check("strobe drive in reset", ddr_dqs_oe, 1'b0);
      check("ready in reset", req_ready, 1'b0);
   endtask : sc_reset_state

   task automatic sc_row_access;
      int t0, t1, t2;
      issue(ddg_pkg::CMD_ACT, 2'h0, 1'b0, t0);
      issue(ddg_pkg::CMD_WR, 2'h0, 1'b0, t1);
      issue(ddg_pkg::CMD_RD, 2'h0, 1'b1, t2);
      @(negedge ref_clk);
      check("read address pins", ddr_addr, 13'h0523);
      check("act to write", t1 - t0, slot(15));
      check("write to read", t2 - t1, slot(70));
      check("write strobe seen", saw_dqs, 1'b1);
   endtask : sc_row_access

   task automatic sc_bank_cycle;
      int t[9];
      issue(ddg_pkg::CMD_ACT, 2'h1, 1'b0, t[0]);
      issue(ddg_pkg::CMD_ACT, 2'h2, 1'b0, t[1]);
      issue(ddg_pkg::CMD_PRE, 2'h1, 1'b0, t[2]);
      issue(ddg_pkg::CMD_PRE, 2'h2, 1'b0, t[3]);
      issue(ddg_pkg::CMD_REF, 2'h0, 1'b0, t[4]);
      issue(ddg_pkg::CMD_MRS, 2'h0, 1'b0, t[5]);
      issue(ddg_pkg::CMD_ACT, 2'h3, 1'b0, t[6]);
      issue(ddg_pkg::CMD_PRE, 2'h3, 1'b0, t[7]);
      issue(ddg_pkg::CMD_ACT, 2'h3, 1'b0, t[8]);
      check("act to act other bank", t[1] - t[0], slot(10));
      check("act to precharge", t[2] - t[0], slot(40));
      check("refresh to mode load", t[5] - t[4], slot(70));
      check("mode load to act", t[6] - t[5], slot(2));
      check("act to act same bank", t[8] - t[6], slot(55));
   endtask : sc_bank_cycle

   task automatic sc_refresh;
      int r0;
      r0 = ref_cnt;
      repeat (1000) @(posedge ref_clk);
      check("refreshes in idle span", (ref_cnt - r0) >= 4, 1'b1);
      check("refresh due seen", saw_pend, 1'b1);
      check("rows closed by guard", open_banks, 4'h0);
      check("device timing faults", viol_cnt, 0);
   endtask : sc_refresh

   initial begin
      repeat (5000) @(posedge ref_clk);
      n_errors++;
      print_verdict();
   end

   initial begin
      rst_n        = 1'b0;
      req_valid    = 1'b0;
      req_cmd      = ddg_pkg::CMD_NOP;
      req_bank     = 2'h0;
      req_addr     = 13'h0000;
      req_auto_pre = 1'b0;
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      sc_reset_state();
      repeat (4) @(posedge ref_clk);
      rst_n <= 1'b1;
      sc_row_access();
      sc_bank_cycle();
      sc_refresh();
      print_verdict();
   end
endmodule : test_ddr_command_timing_guard
